// ---- rtl/adcs_sequencer.sv ----
/*
 * channel sequencer and AHB-Lite register slave for a 10-bit
 * successive-approximation converter.
 * assumes the converter presents a valid code at the end of the
 * convert window, and one clock hclk with async reset hresetn.
 */
`include "adcs_regs.svh"
// Notes on behaviour
// R01 - every result is a 10-bit unsigned converter code.
// R02 - the automatic scans cover 11 channels and store each result.
// R03 - software can order one sample and conversion of a chosen channel.
// R04 - scans visit channels 0 to 10 only; higher ones need single selection.
// R05 - channels 8 and 10 read the config pins by five, 12 and 13 by two.
// R06 - channel numbers map to fixed inputs, e.g. 1 bus, 15 and 16 the 3.3 V rails.
// R07 - current channels 3, 5, 7 and 9 are reported undivided.
// R08 - full scale of a voltage channel is 1.2 V after its divider.
// R09 - each result stays readable while conversions go on.
// R10 - conversion takes 12 clocks, then a 2-clock completion pulse follows.
// R11 - continuous single mode restarts sampling after the pulse ends.
// R12 - round robin steps upward through the channels endlessly, overwriting.
// R13 - one-shot scan stops after the last channel with one completion pulse.
// R14 - the channel select field is five bits wide.
// R15 - mode or channel changes apply only after the running result is stored.
module adcs_sequencer
   import adcs_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input  wire logic [9:0]  adc_code,
   output adcs_conv_t       conv,
   output logic             done_pulse,
   output logic             irq
);
   // ***********************************
   // divider ratio per channel, 0 = none
   // ***********************************
   function automatic logic [4:0] adcs_ratio(input logic [4:0] c);
      logic [4:0] r;
      r = 5'h03;
      case (c)
         5'h00, 5'h03, 5'h05, 5'h07, 5'h09: r = 5'h00; // R07
         `ADCS_CH_BUS_VOLT, 5'h02, 5'h04: r = 5'h19; // R06
         5'h06, 5'h0e: r = 5'h05;
         `ADCS_CH_CFG1_SUPPLY_DIV_FIVE,
         `ADCS_CH_CFG2_SUPPLY_DIV_FIVE: r = 5'h05; // R05
         `ADCS_CH_CFG1_DATA_DIV_TWO,
         `ADCS_CH_CFG2_DATA_DIV_TWO: r = 5'h02; // R05
         5'h12, 5'h13: r = 5'h02;
         5'h0b: r = 5'h01;
         `ADCS_CH_SUPPLY_INPUT_3V3,
         `ADCS_CH_SWITCHED_OUTPUT_3V3: r = 5'h03; // R06
         default: r = 5'h03;
      endcase
      return r;
   endfunction

   function automatic logic [7:0] adcs_load(input logic [7:0] len);
      return (len == 8'h00) ? 8'h00 : len - 8'h01;
   endfunction

   // ***********************************
   // state
   // ***********************************
   adcs_state_t state;
   adcs_state_t next_state;
   logic [7:0]  cnt;
   logic [7:0]  next_cnt;
   adcs_mode_t  act_mode;
   adcs_mode_t  next_mode;
   logic        act_cont;
   logic        next_cont;
   logic [4:0]  act_ch;
   logic [4:0]  next_ch;
   logic        ctrl_en;
   adcs_mode_t  ctrl_mode;
   logic        ctrl_cont;
   logic [4:0]  ctrl_ch;
   logic [7:0]  tim_wake;
   logic [7:0]  tim_sample;
   logic [1:0]  sts;
   logic [1:0]  msk;
   logic [9:0]  last_code;
   logic [4:0]  last_ch;
   logic [9:0]  res_mem [0:31];
   logic        dp_wr;
   logic [7:0]  dp_addr;

   // ***********************************
   // bus decode
   // ***********************************
   wire         ap_valid = hsel & htrans[1] & hready;
   wire         wr_ctrl  = dp_wr && dp_addr == `ADCS_OFF_CTRL;
   wire         wr_tim   = dp_wr && dp_addr == `ADCS_OFF_TIMING;
   wire         wr_sts   = dp_wr && dp_addr == `ADCS_OFF_STATUS;
   wire         wr_msk   = dp_wr && dp_addr == `ADCS_OFF_MASK;
   wire  [7:0]  ra       = haddr[7:0];
   wire         rd_res   = ra[`ADCS_RES_BIT] && ra[1:0] == 2'h0;
   wire  [31:0] rd_ctrl  = {23'h0, ctrl_ch, ctrl_en, ctrl_cont, ctrl_mode};
   wire  [31:0] rd_tim   = {16'h0, tim_sample, tim_wake};
   wire  [31:0] rd_sts   = {18'h0, act_ch, ~state[0], 6'h0, sts};
   wire  [31:0] rd_last  = {3'h0, adcs_ratio(last_ch), 3'h0, last_ch,
                             6'h0, last_code}; // R08
   wire  [31:0] rd_res_w = {22'h0, res_mem[ra[6:2]]}; // R09
   wire  [31:0] next_rdata =
      (!ap_valid || hwrite)       ? 32'h0 :
      rd_res                      ? rd_res_w :
      ra == `ADCS_OFF_CTRL        ? rd_ctrl :
      ra == `ADCS_OFF_TIMING      ? rd_tim :
      ra == `ADCS_OFF_STATUS      ? rd_sts :
      ra == `ADCS_OFF_MASK        ? {30'h0, msk} :
      ra == `ADCS_OFF_LAST        ? rd_last : 32'h0;

   // ***********************************
   // sequencing decode
   // ***********************************
   wire         cnt_zero  = cnt == 8'h00;
   wire         conv_end  = state == ST_CONVERT && cnt_zero;
   wire         is_scan   = act_mode == MODE_ROBIN || act_mode == MODE_ONCE;
   wire         scan_last = act_ch == `ADCS_LAST_AUTO_CH;
   wire         once_end  = act_mode == MODE_ONCE && scan_last; // R13
   wire         single_end = !is_scan && !act_cont; // R03
   wire         hw_stop   = state == ST_NOTIFY && cnt_zero
                            && (single_end || once_end);
   wire         ctrl_scan = ctrl_mode == MODE_ROBIN || ctrl_mode == MODE_ONCE;
   wire  [4:0]  step_ch   = scan_last ? 5'h00 : act_ch + 5'h01; // R12
   wire  [4:0]  start_ch  = ctrl_scan ? 5'h00 : ctrl_ch; // R04
   wire  [4:0]  resume_ch = !ctrl_scan ? ctrl_ch :
                            is_scan ? step_ch : 5'h00; // R04
   wire         pulse_ok  = act_mode != MODE_ONCE || scan_last; // R13
   wire  [1:0]  sts_set   = {conv_end && once_end, conv_end};
   wire  [1:0]  sts_clr   = wr_sts ? hwdata[1:0] : 2'h0;

   always_comb begin
      next_state = state;
      next_cnt   = cnt_zero ? 8'h00 : cnt - 8'h01;
      next_mode  = act_mode;
      next_cont  = act_cont;
      next_ch    = act_ch;
      case (state)
         ST_IDLE: begin
            if (ctrl_en) begin
               next_state = ST_WAKE;
               next_cnt   = adcs_load(tim_wake);
               next_mode  = ctrl_mode;
               next_cont  = ctrl_cont;
               next_ch    = start_ch;
            end
         end
         ST_WAKE: begin
            if (cnt_zero) begin
               next_state = ST_SAMPLE;
               next_cnt   = adcs_load(tim_sample);
            end
         end
         ST_SAMPLE: begin
            if (cnt_zero) begin
               next_state = ST_CONVERT;
               next_cnt   = `ADCS_CONVERT_CYC - 8'h01; // R10
            end
         end
         ST_CONVERT: begin
            if (cnt_zero) begin
               next_state = ST_NOTIFY;
               next_cnt   = `ADCS_RESULT_INTERRUPT_TIME - 8'h01; // R10
            end
         end
         ST_NOTIFY: begin
            if (cnt_zero) begin
               if (!ctrl_en || single_end || once_end) begin
                  next_state = ST_IDLE;
               end else begin
                  // while running, new settings are picked up only here
                  next_state = ST_SAMPLE; // R11 R12 R15
                  next_cnt   = adcs_load(tim_sample);
                  next_mode  = ctrl_mode;
                  next_cont  = ctrl_cont;
                  next_ch    = resume_ch;
               end
            end
         end
         default: begin
            next_state = ST_IDLE;
            next_cnt   = 8'h00;
         end
      endcase
   end

   // ***********************************
   // registers
   // ***********************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state    <= ST_IDLE;
         cnt      <= 8'h00;
         act_mode <= MODE_SINGLE;
         act_cont <= 1'b0;
         act_ch   <= 5'h00;
      end else begin
         state    <= next_state;
         cnt      <= next_cnt;
         act_mode <= next_mode;
         act_cont <= next_cont;
         act_ch   <= next_ch;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_en    <= 1'b0;
         ctrl_mode  <= MODE_SINGLE;
         ctrl_cont  <= 1'b0;
         ctrl_ch    <= 5'h00;
      end else if (wr_ctrl) begin
         ctrl_en    <= hwdata[`ADCS_CTRL_EN];
         ctrl_mode  <= adcs_mode_t'(hwdata[`ADCS_CTRL_MODE]);
         ctrl_cont  <= hwdata[`ADCS_CTRL_CONT];
         ctrl_ch    <= hwdata[`ADCS_CTRL_CH]; // R14
      end else if (hw_stop) begin
         ctrl_en    <= 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tim_wake   <= `ADCS_WAKE_RST;
         tim_sample <= `ADCS_SAMPLE_RST;
         msk        <= 2'h0;
         sts        <= 2'h0;
         irq        <= 1'b0;
      end else begin
         if (wr_tim) begin
            tim_wake   <= hwdata[`ADCS_TIM_WAKE];
            tim_sample <= hwdata[`ADCS_TIM_SAMPLE];
         end
         if (wr_msk) begin
            msk <= hwdata[1:0];
         end
         sts <= (sts & ~sts_clr) | sts_set;
         irq <= |(sts & msk);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         last_code <= 10'h000;
         last_ch   <= 5'h00;
      end else if (conv_end) begin
         last_code <= adc_code; // R01
         last_ch   <= act_ch;
      end
   end

   // one stored result per channel
   for (genvar i = 0; i < 32; i++) begin : g_res
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            res_mem[i] <= 10'h000;
         end else if (conv_end && act_ch == 5'(i)) begin
            res_mem[i] <= adc_code; // R02 R09 R12
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_wr     <= 1'b0;
         dp_addr   <= 8'h00;
         hrdata    <= 32'h0;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         dp_wr     <= ap_valid && hwrite;
         dp_addr   <= ra;
         hrdata    <= next_rdata;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   // converter pins follow the next state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         conv       <= '0;
         done_pulse <= 1'b0;
      end else begin
         conv.power   <= next_state != ST_IDLE;
         conv.sample  <= next_state == ST_SAMPLE;
         conv.convert <= next_state == ST_CONVERT; // R10
         conv.ch      <= next_ch;
         done_pulse   <= next_state == ST_NOTIFY && pulse_ok; // R10 R13
      end
   end

   // ***********************************
   // assertions
   // ***********************************
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // convert cycles so far, saturating
   logic [3:0]  cv_len;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cv_len <= 4'h0;
      end else begin
         cv_len <= !conv.convert ? 4'h0 : (cv_len == 4'hf) ? cv_len : cv_len + 4'h1;
      end
   end

   a_convert_twelve: assert property ( // R10
      $fell(conv.convert) |-> cv_len == 4'hc)
      else $error("convert window not twelve cycles");

   a_pulse_two: assert property ( // R10
      $rose(done_pulse) |-> done_pulse [*2] ##1 !done_pulse)
      else $error("completion pulse not two cycles");

   a_scan_range: assert property ( // R04
      (conv.sample && is_scan) |-> conv.ch <= `ADCS_LAST_AUTO_CH)
      else $error("scan reached a non-sequenced channel");

   a_robin_step: assert property ( // R12
      (state == ST_NOTIFY && next_state == ST_SAMPLE
       && act_mode == MODE_ROBIN && ctrl_mode == MODE_ROBIN)
      |=> conv.ch == (($past(act_ch) == 5'h0a) ? 5'h00 : $past(act_ch) + 5'h01))
      else $error("round robin did not step to next channel");

   a_result_store: assert property ( // R09
      conv_end |=> res_mem[$past(act_ch)] == $past(adc_code)
                   && last_code == $past(adc_code))
      else $error("result not stored");

   a_cfg_hold: assert property ( // R15
      (state == ST_CONVERT || state == ST_SAMPLE) && next_state != ST_IDLE
      && state == next_state |=> $stable(conv.ch) && $stable(act_mode))
      else $error("channel changed during conversion");

   a_single_stop: assert property ( // R03
      (state == ST_NOTIFY && cnt_zero && single_end)
      |=> state == ST_IDLE && !ctrl_en)
      else $error("single conversion did not stop");

   a_cont_restart: assert property ( // R11
      (state == ST_NOTIFY && cnt_zero && !is_scan && act_cont && ctrl_en
       && !ctrl_scan) |=> conv.sample ##0 conv.ch == $past(ctrl_ch))
      else $error("continuous mode did not restart");

   a_once_end: assert property ( // R13
      (conv_end && once_end) |=> sts[`ADCS_ST_SCAN] ##1 done_pulse
      ##2 state == ST_IDLE)
      else $error("one-shot scan did not finish");

   a_once_quiet: assert property ( // R13
      (state == ST_NOTIFY && act_mode == MODE_ONCE && !scan_last) |-> !done_pulse)
      else $error("one-shot pulsed before last channel");

   c_robin_wrap: cover property (
      state == ST_NOTIFY && act_mode == MODE_ROBIN && scan_last && next_state == ST_SAMPLE);
   c_once_done: cover property (conv_end && once_end);
   c_cont_again: cover property (
      state == ST_NOTIFY && next_state == ST_SAMPLE && !is_scan);
   c_irq: cover property ($rose(irq));
endmodule

// ---- include/adcs_regs.svh ----
/*
 * register map, field positions, reset values and timing counts
 * of the converter sequencer.
 * assumes a 32-bit bus where each register takes one aligned word.
 */
`ifndef ADCS_REGS_SVH
`define ADCS_REGS_SVH
// ***********************************
// offsets
// ***********************************
`define ADCS_OFF_CTRL     8'h00
`define ADCS_OFF_TIMING   8'h04
`define ADCS_OFF_STATUS   8'h08
`define ADCS_OFF_MASK     8'h0c
`define ADCS_OFF_LAST     8'h10
`define ADCS_RES_BIT      7
// ***********************************
// fields
// ***********************************
`define ADCS_CTRL_MODE    1:0
`define ADCS_CTRL_CONT    2
`define ADCS_CTRL_EN      3
`define ADCS_CTRL_CH      8:4
`define ADCS_TIM_WAKE     7:0
`define ADCS_TIM_SAMPLE   15:8
`define ADCS_ST_CONV      0
`define ADCS_ST_SCAN      1
`define ADCS_ST_BUSY      8
`define ADCS_ST_CH        13:9
`define ADCS_LAST_CODE    9:0
`define ADCS_LAST_CH      20:16
`define ADCS_LAST_RATIO   28:24
// ***********************************
// reset values
// ***********************************
`define ADCS_WAKE_RST     8'h04
`define ADCS_SAMPLE_RST   8'h04
// ***********************************
// timing and channels
// ***********************************
`define ADCS_CONVERT_CYC  8'h0c
`define ADCS_RESULT_INTERRUPT_TIME 8'h02
`define ADCS_LAST_AUTO_CH 5'h0a
`define ADCS_CH_BUS_VOLT  5'h01
`define ADCS_CH_CFG1_SUPPLY_DIV_FIVE 5'h08
`define ADCS_CH_CFG2_SUPPLY_DIV_FIVE 5'h0a
`define ADCS_CH_CFG1_DATA_DIV_TWO    5'h0c
`define ADCS_CH_CFG2_DATA_DIV_TWO    5'h0d
`define ADCS_CH_SUPPLY_INPUT_3V3     5'h0f
`define ADCS_CH_SWITCHED_OUTPUT_3V3  5'h10
`endif

// ---- include/adcs_pkg.sv ----
/*
 * types of the converter sequencer.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package adcs_pkg;
   typedef enum logic [4:0] {
      ST_IDLE    = 5'b00001,
      ST_WAKE    = 5'b00010,
      ST_SAMPLE  = 5'b00100,
      ST_CONVERT = 5'b01000,
      ST_NOTIFY  = 5'b10000
   } adcs_state_t;
   typedef enum logic [1:0] {
      MODE_SINGLE = 2'h0,
      MODE_ROBIN  = 2'h1,
      MODE_ONCE   = 2'h2,
      MODE_RSVD   = 2'h3
   } adcs_mode_t;
   typedef struct packed {
      logic       power;
      logic       sample;
      logic       convert;
      logic [4:0] ch;
   } adcs_conv_t;
endpackage

// ---- testbench/adcs_adc_model.sv ----
/* model of the analog converter and its input mux.
   assumes conv from the sequencer and one clock hclk. */
module adcs_adc_model
   import adcs_pkg::*;
(
   input  wire logic       hclk,
   input  wire adcs_conv_t conv,
   output logic [9:0]      adc_code
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [9:0] junk = 10'h2a5;
   // code follows the channel; toggling junk outside convert
   always @(posedge hclk) begin
      junk <= ~junk;
   end
   assign adc_code = conv.convert ? {conv.ch, ~conv.ch} : junk;
endmodule

// ---- testbench/testbench.sv ----
/* self-checking bench of the converter sequencer.
   assumes the converter model beside it and one 50 MHz clock. */
`include "adcs_regs.svh"
module testbench
   import adcs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic        hreadyout;
   logic        hresp;
   logic [31:0] hrdata;
   logic [9:0]  adc_code;
   adcs_conv_t  conv;
   logic        done_pulse;
   logic        irq;
   logic [31:0] exp_rd[$];
   logic [31:0] exp_mk[$];
   logic [4:0]  exp_ch[$];
   logic        rd_dp = 1'b0;
   logic        smp_q = 1'b0;
   logic        cv_q = 1'b0;
   logic        dp_q = 1'b0;
   int          cv_n = 0;
   int          dp_n = 0;
   int          pulses = 0;
   int          mismatches = 0;
   int          tests_run = 0;

   always #10 hclk = ~hclk;

   adcs_sequencer dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .adc_code(adc_code), .conv(conv), .done_pulse(done_pulse), .irq(irq));
   adcs_adc_model adc (.hclk(hclk), .conv(conv), .adc_code(adc_code));

   // *****
   // checking
   // *****
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask

   function automatic logic [4:0] ratio(input logic [4:0] c);
      case (c)
         5'h00, 5'h03, 5'h05, 5'h07, 5'h09: ratio = 5'h00;
         5'h01, 5'h02, 5'h04: ratio = 5'h19;
         5'h06, 5'h08, 5'h0a, 5'h0e: ratio = 5'h05;
         5'h0b: ratio = 5'h01;
         5'h0c, 5'h0d, 5'h12, 5'h13: ratio = 5'h02;
         default: ratio = 5'h03;
      endcase
   endfunction

   always @(posedge hclk) begin
      rd_dp <= hsel && htrans[1] && !hwrite && hreadyout;
      smp_q <= conv.sample;
      cv_q <= conv.convert;
      dp_q <= done_pulse;
      cv_n <= conv.convert ? cv_n + 1 : 0;
      dp_n <= done_pulse ? dp_n + 1 : 0;
      if (conv.sample === 1'b1 || conv.convert === 1'b1)
         chk("power", 32'h1, {31'h0, conv.power});
      if (rd_dp && hreadyout) begin
         chk("hrdata", exp_rd.pop_front(), hrdata & exp_mk.pop_front());
         chk("hresp", 32'h0, {31'h0, hresp});
      end
      if (conv.sample === 1'b1 && !smp_q) begin
         if (exp_ch.size() == 0)
            chk("extra sample", 32'h0, 32'h1);
         else
            chk("channel", {27'h0, exp_ch.pop_front()}, {27'h0, conv.ch});
      end
      if (cv_q && conv.convert !== 1'b1)
         chk("convert cycles", 32'h0c, cv_n);
      if (dp_q && done_pulse !== 1'b1)
         chk("pulse cycles", 32'h2, dp_n);
      if (done_pulse === 1'b1 && !dp_q)
         pulses <= pulses + 1;
   end

   // *****
   // bus and waits
   // *****
   task automatic timeout;
      mismatches++;
      $display("wrong value wait expected answer seen none");
      end_of_test;
   endtask

   task automatic hold_ready;
      int n;
      n = 0;
      do begin
         @(negedge hclk);
         n++;
         if (n > 50)
            timeout;
      end while (hreadyout !== 1'b1);
      @(posedge hclk);
   endtask

   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] m);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= wr;
      hold_ready;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wr ? d : 32'h0;
      if (!wr) begin
         exp_rd.push_back(d & m);
         exp_mk.push_back(m);
      end
      hold_ready;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 32'h0);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e,
                     input logic [31:0] m = 32'hffffffff);
      bus(1'b0, a, e, m);
   endtask

   // what: 0 pulse seen, 1 channel notes used up, 2 converter off
   task automatic wait_for(input int what, input int lim);
      int n;
      for (n = 0; n < lim; n++) begin
         @(negedge hclk);
         if (what == 0 && done_pulse === 1'b1)
            break;
         if (what == 1 && exp_ch.size() == 0)
            break;
         if (what == 2 && conv.power === 1'b0)
            break;
      end
      if (n == lim)
         timeout;
      @(posedge hclk);
   endtask

   task automatic irq_is(input logic e);
      @(posedge hclk);
      @(negedge hclk);
      chk("irq", {31'h0, e}, {31'h0, irq});
      @(posedge hclk);
   endtask

   // *****
   // scenarios
   // *****
   initial begin
      logic [4:0]  chs[9];
      logic [31:0] tm;
      chs = '{5'h03, 5'h08, 5'h0c, 5'h0d, 5'h0f, 5'h10, 5'h01, 5'h1f, 5'h0a};
      void'($urandom(85));
      chs[8] = 5'($urandom_range(31));
      tm = {16'h0, 8'($urandom_range(4, 1)), 8'($urandom_range(4, 1))};
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd(`ADCS_OFF_CTRL, 32'h0);
      rd(`ADCS_OFF_TIMING, 32'h0404);
      rd(`ADCS_OFF_STATUS, 32'h0);
      rd(`ADCS_OFF_MASK, 32'h0);
      rd(`ADCS_OFF_LAST, 32'h0);
      rd(8'h80, 32'h0);
      wr(8'h14, 32'hffffffff);
      rd(8'h14, 32'h0);
      wr(`ADCS_OFF_TIMING, tm);
      rd(`ADCS_OFF_TIMING, tm);
      foreach (chs[i]) begin
         exp_ch.push_back(chs[i]);
         wr(`ADCS_OFF_CTRL, {23'h0, chs[i], 2'h2, (i == 8) ? 2'h3 : 2'h0});
         wait_for(0, 300);
         wait_for(2, 50);
         rd(`ADCS_OFF_LAST, {3'h0, ratio(chs[i]), 3'h0, chs[i], 6'h0, chs[i], ~chs[i]});
         rd({1'b1, chs[i], 2'h0}, {22'h0, chs[i], ~chs[i]});
         rd(`ADCS_OFF_CTRL, 32'h0, 32'h8);
      end
      rd(`ADCS_OFF_STATUS, 32'h1, 32'h3);
      irq_is(1'b0);
      wr(`ADCS_OFF_MASK, 32'h1);
      irq_is(1'b1);
      wr(`ADCS_OFF_STATUS, 32'h1);
      irq_is(1'b0);
      for (int c = 0; c < 11; c++)
         exp_ch.push_back(5'(c));
      wr(`ADCS_OFF_MASK, 32'h2);
      pulses = 0;
      wr(`ADCS_OFF_CTRL, 32'h0a);
      wait_for(0, 600);
      wait_for(2, 50);
      repeat (40) @(posedge hclk);
      chk("pulses", 32'h1, pulses);
      rd(`ADCS_OFF_STATUS, 32'h2, 32'h2);
      irq_is(1'b1);
      for (int c = 0; c < 11; c++)
         rd({1'b1, 5'(c), 2'h0}, {22'h0, 5'(c), ~5'(c)});
      exp_ch.push_back(5'h06);
      exp_ch.push_back(5'h06);
      wr(`ADCS_OFF_CTRL, 32'h6c);
      wait_for(1, 300);
      exp_ch.push_back(5'h09);
      exp_ch.push_back(5'h09);
      wr(`ADCS_OFF_CTRL, 32'h9c);
      wait_for(1, 300);
      wr(`ADCS_OFF_CTRL, 32'h0);
      wait_for(2, 100);
      for (int c = 0; c < 13; c++)
         exp_ch.push_back(5'(c % 11));
      wr(`ADCS_OFF_CTRL, 32'h09);
      rd(8'h98, {22'h0, 5'h06, ~5'h06});
      wait_for(1, 800);
      wr(`ADCS_OFF_CTRL, 32'h0);
      wait_for(2, 100);
      repeat (30) @(posedge hclk);
      end_of_test;
   end
endmodule
